// ### logic/ecab_decode.sv
// address window, bank and row decode of the array board
// assumes word addresses and a base aligned to 4 K words
`timescale 1ns/1ps
module ecab_decode (
    // bus request
    input  wire logic [ecab_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                        rd_i,
    // board setting
    input  wire logic [ecab_pkg::BASE_W-1:0] base_i,
    input  wire logic                        size_hi_i,
    input  wire logic                        size_lo_i,
    // decode result
    output ecab_pkg::ecab_dec_t              dec_o
);
    logic [ecab_pkg::ADDR_W-1:0] start;
    logic [ecab_pkg::ADDR_W-1:0] offset;
    logic [2:0]                  banks;
    logic [17:0]                 limit;
    logic                        hit;
    logic [1:0]                  idx;
    logic [3:0]                  en;

    // window from base up to base plus capacity minus one
    assign start  = {base_i, 12'h000};
    assign offset = addr_i - start;
    assign banks  = ({size_hi_i, size_lo_i} == 2'h0) ? 3'h4 : {1'b0, size_hi_i, size_lo_i};
    assign limit  = {banks, 15'h0000};
    assign hit    = (addr_i >= start) && ({2'h0, offset} < {4'h0, limit});
    assign idx    = offset[ecab_pkg::BANK_SHIFT+1:ecab_pkg::BANK_SHIFT];

    // one enable per bank
    genvar b;
    generate
        for (b = 0; b < ecab_pkg::BANK_N; b++) begin : g_bank
            assign en[b] = hit && (idx == 2'(b));
        end
    endgenerate

    // double word read uses both rows, a write only its own row
    assign dec_o = '{hit      : hit,
                     bank_en  : en,
                     row_even : hit && (rd_i || !addr_i[0]),
                     row_odd  : hit && (rd_i || addr_i[0])};
endmodule

// ### logic/ecab_pkg.sv
// constants, types and state layout of the array board decode block
// assumes a single 100 MHz clock domain and word addressing on the system bus
package ecab_pkg;

    // ------------------------------------------------------------
    // system bus and array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W     = 20;  // word address width
    localparam int BASE_W     = 8;   // base setting width
    localparam int BASE_SHIFT = 12;  // 4 K words = 8 KB per base step
    localparam int BANK_SHIFT = 15;  // 32 K words = 64 KB per bank
    localparam int BANK_N     = 4;   // banks on a full board
    localparam int WORD_W     = 22;  // stored word: data plus check
    localparam int DATA_W     = 16;  // data bits seen on the bus

    // ------------------------------------------------------------
    // register map, byte offsets on the avalon slave
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK   = 4'h8;
    localparam int CTRL_SIZE_HI_BIT   = 8;
    localparam int CTRL_SIZE_LO_BIT   = 9;
    localparam int CTRL_IORST_BIT     = 16;
    localparam int ST_CORR_BIT        = 0;
    localparam int ST_UNC_BIT         = 1;
    localparam logic [7:0] BASE_RST   = 8'h00;
    localparam logic       SIZE_RST   = 1'b0;  // both jumpers off: 256 KB
    localparam logic [1:0] MASK_RST   = 2'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } ecab_bus_st_t;

    typedef struct packed {
        logic       hit;
        logic [3:0] bank_en;
        logic       row_even;
        logic       row_odd;
    } ecab_dec_t;

    typedef struct packed {
        ecab_bus_st_t bus_st;
        logic         waitreq;
        logic [31:0]  readdata;
        logic [7:0]   base;
        logic         size_hi;
        logic         size_lo;
        logic [1:0]   status;
        logic [1:0]   mask;
        logic         irq;
        logic         led_corr;
        logic         led_unc;
        ecab_dec_t    dec;
        logic [31:0]  rd_data;
    } ecab_state_t;

endpackage

// ### logic/ecab_top.sv
// array board decode: window decode, row and bank enables, error flags,
// avalon register slave with one wait state and a level interrupt
// assumes one clock, synchronous inputs, error pulses from the controller board
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module ecab_top (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         ce_i,
    // avalon register slave
    input  wire logic [3:0]                   avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [31:0]                  avs_writedata_i,
    input  wire logic [3:0]                   avs_byteenable_i,
    output logic [31:0]                       avs_readdata_o,
    output logic                              avs_waitrequest_o,
    // system bus address side
    input  wire logic [ecab_pkg::ADDR_W-1:0]  sys_addr_i,
    input  wire logic                         sys_req_i,
    input  wire logic                         sys_rd_i,
    // array words and controller error reports
    input  wire logic [ecab_pkg::WORD_W-1:0]  arr_word_even_i,
    input  wire logic [ecab_pkg::WORD_W-1:0]  arr_word_odd_i,
    input  wire logic                         ctl_corr_err_i,
    input  wire logic                         ctl_unc_err_i,
    // board outputs
    output logic                              sel_o,
    output logic [3:0]                        bank_en_o,
    output logic                              row_even_en_o,
    output logic                              row_odd_en_o,
    output logic [31:0]                       rd_data_o,
    output logic                              led_corr_o,
    output logic                              led_unc_o,
    output logic                              irq_o
);
    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    ecab_pkg::ecab_state_t s_r;
    ecab_pkg::ecab_state_t s_nxt;
    ecab_pkg::ecab_dec_t   dec;
    logic                  acc;
    logic                  wr_ctrl;
    logic                  wr_status;
    logic                  wr_mask;
    logic                  iorst;
    logic [1:0]            events;
    logic [1:0]            w1c;

    ecab_decode u_decode (
        .addr_i    (sys_addr_i),
        .rd_i      (sys_rd_i),
        .base_i    (s_r.base),
        .size_hi_i (s_r.size_hi),
        .size_lo_i (s_r.size_lo),
        .dec_o     (dec)
    );

    // register writes commit in the cycle waitrequest is low
    assign acc       = (s_r.bus_st == ecab_pkg::BUS_ACK) && (avs_read_i || avs_write_i);
    assign wr_ctrl   = acc && avs_write_i && (avs_address_i == ecab_pkg::OFS_CTRL);
    assign wr_status = acc && avs_write_i && (avs_address_i == ecab_pkg::OFS_STATUS) && avs_byteenable_i[0];
    assign wr_mask   = acc && avs_write_i && (avs_address_i == ecab_pkg::OFS_MASK) && avs_byteenable_i[0];
    assign iorst     = wr_ctrl && avs_byteenable_i[2] && avs_writedata_i[ecab_pkg::CTRL_IORST_BIT];
    assign events    = {ctl_unc_err_i, ctl_corr_err_i};
    assign w1c       = wr_status ? avs_writedata_i[1:0] : 2'h0;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (ce_i) begin
            // bus slave: one wait state, then answer
            case (s_r.bus_st)
                ecab_pkg::BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        s_nxt.bus_st   = ecab_pkg::BUS_ACK;
                        s_nxt.waitreq  = 1'b0;
                        s_nxt.readdata = 32'h0000_0000;
                        case (avs_address_i)
                            ecab_pkg::OFS_CTRL: begin
                                s_nxt.readdata[7:0] = s_r.base;
                                s_nxt.readdata[ecab_pkg::CTRL_SIZE_HI_BIT] = s_r.size_hi;
                                s_nxt.readdata[ecab_pkg::CTRL_SIZE_LO_BIT] = s_r.size_lo;
                            end
                            ecab_pkg::OFS_STATUS: s_nxt.readdata[1:0] = s_r.status;
                            ecab_pkg::OFS_MASK:   s_nxt.readdata[1:0] = s_r.mask;
                            default:              s_nxt.readdata = 32'h0000_0000;
                        endcase
                    end
                end
                ecab_pkg::BUS_ACK: begin
                    s_nxt.bus_st  = ecab_pkg::BUS_IDLE;
                    s_nxt.waitreq = 1'b1;
                end
                default: begin
                    s_nxt.bus_st  = ecab_pkg::BUS_IDLE;
                    s_nxt.waitreq = 1'b1;
                end
            endcase
            // control register fields
            if (wr_ctrl && avs_byteenable_i[0]) begin
                s_nxt.base = avs_writedata_i[7:0];
            end
            if (wr_ctrl && avs_byteenable_i[1]) begin
                s_nxt.size_hi = avs_writedata_i[ecab_pkg::CTRL_SIZE_HI_BIT];
                s_nxt.size_lo = avs_writedata_i[ecab_pkg::CTRL_SIZE_LO_BIT];
            end
            if (wr_mask) begin
                s_nxt.mask = avs_writedata_i[1:0];
            end
            // sticky status, set wins over write-one-to-clear
            s_nxt.status = (s_r.status & ~w1c) | events;
            s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
            // indicators: two flags, cleared only by reset or I/O reset
            s_nxt.led_corr = (s_r.led_corr && !iorst) || ctl_corr_err_i;
            s_nxt.led_unc  = (s_r.led_unc && !iorst) || ctl_unc_err_i;
            // board select and enables for this bus cycle
            s_nxt.dec = sys_req_i ? dec : '0;
            // only the 16 data bits of each word reach the bus
            if (sys_req_i && sys_rd_i && dec.hit) begin
                s_nxt.rd_data = {arr_word_odd_i[ecab_pkg::DATA_W-1:0],
                                 arr_word_even_i[ecab_pkg::DATA_W-1:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r         <= '0;
            s_r.bus_st  <= ecab_pkg::BUS_IDLE;
            s_r.waitreq <= 1'b1;
            s_r.base    <= ecab_pkg::BASE_RST;
            s_r.size_hi <= ecab_pkg::SIZE_RST;
            s_r.size_lo <= ecab_pkg::SIZE_RST;
            s_r.mask    <= ecab_pkg::MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign avs_readdata_o    = s_r.readdata;
    assign avs_waitrequest_o = s_r.waitreq;
    assign sel_o             = s_r.dec.hit;
    assign bank_en_o         = s_r.dec.bank_en;
    assign row_even_en_o     = s_r.dec.row_even;
    assign row_odd_en_o      = s_r.dec.row_odd;
    assign rd_data_o         = s_r.rd_data;
    assign led_corr_o        = s_r.led_corr;
    assign led_unc_o         = s_r.led_unc;
    assign irq_o             = s_r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_LED_CORR_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && ctl_corr_err_i |=> led_corr_o)
        else $error("correctable flag not set by error");
    AST_LED_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        led_corr_o && !(ce_i && iorst) |=> led_corr_o)
        else $error("correctable flag dropped without I/O reset");
    AST_FLAGS_APART: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && ctl_corr_err_i && !ctl_unc_err_i && !led_unc_o |=> !led_unc_o)
        else $error("corrected error set the uncorrectable flag");
    AST_LED_UNC_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && iorst |=> led_unc_o == $past(ctl_unc_err_i))
        else $error("uncorrectable flag wrong after I/O reset");
    AST_BASE_MISS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && sys_req_i && (sys_addr_i[19:12] < s_r.base) |=> !sel_o)
        else $error("select below base");
    AST_BASE_ORDER: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && sys_req_i && (sys_addr_i == {s_r.base, 12'h000}) |=> sel_o && bank_en_o[0])
        else $error("base word not selected in bank 0");
    AST_SIZE_64K: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && sys_req_i && !s_r.size_hi && s_r.size_lo && (s_r.base < 8'hf8)
        && (sys_addr_i == {s_r.base, 12'h000} + 20'h08000) |=> !sel_o)
        else $error("64 KB board answered past its end");
    AST_BANK_ONEHOT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sel_o |-> $onehot(bank_en_o))
        else $error("bank enables not one-hot");
    AST_WRITE_ROW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && sys_req_i && !sys_rd_i && dec.hit |=> row_even_en_o != row_odd_en_o)
        else $error("write enabled both rows");
    AST_READ_ROWS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && sys_req_i && sys_rd_i && dec.hit |=> row_even_en_o && row_odd_en_o)
        else $error("double word read missed a row");
    AST_DATA_ONLY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && sys_req_i && sys_rd_i && dec.hit
        |=> rd_data_o == {$past(arr_word_odd_i[15:0]), $past(arr_word_even_i[15:0])})
        else $error("read data not the data bits");
    AST_ONE_WAIT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ce_i && avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("slave did not answer after one wait state");
endmodule

// ### testbench/ecab_array_board_decode_tb.sv
// self-checking bench of the array board decode block
// assumes the controller model beside it and an avalon master in here
`timescale 1ns/1ps
module ecab_array_board_decode_tb;
    logic        clk_i, reset_n_i, avs_read_i, avs_write_i, sys_req_i, sys_rd_i, corr_cmd, unc_cmd;
    logic        ctl_corr, ctl_unc, avs_waitrequest_o, sel_o, row_even_en_o, row_odd_en_o;
    logic        led_corr_o, led_unc_o, irq_o, ce;
    logic [3:0]  avs_address_i, bank_en_o;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd_data_o, rdv, rd_exp;
    logic [19:0] sys_addr_i;
    logic [15:0] pattern;
    logic [21:0] w_even, w_odd;
    int          err_total, checked, cycles;

    // clock
    always #5 clk_i = ~clk_i;

    ecab_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .sys_addr_i(sys_addr_i), .sys_req_i(sys_req_i), .sys_rd_i(sys_rd_i), .arr_word_even_i(w_even),
        .arr_word_odd_i(w_odd), .ctl_corr_err_i(ctl_corr), .ctl_unc_err_i(ctl_unc), .sel_o(sel_o),
        .bank_en_o(bank_en_o), .row_even_en_o(row_even_en_o), .row_odd_en_o(row_odd_en_o),
        .rd_data_o(rd_data_o), .led_corr_o(led_corr_o), .led_unc_o(led_unc_o), .irq_o(irq_o));
    ecab_ctl_model partner (.clk_i(clk_i), .reset_n_i(reset_n_i), .pattern_i(pattern), .corr_cmd_i(corr_cmd),
        .unc_cmd_i(unc_cmd), .arr_word_even_o(w_even), .arr_word_odd_o(w_odd),
        .ctl_corr_err_o(ctl_corr), .ctl_unc_err_o(ctl_unc));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // avalon access, held until waitrequest is sampled low
    task avm(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
        rdv = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // one system bus request, outputs sampled mid-cycle
    task sys(input logic [19:0] a, input logic rd);
        @(posedge clk_i);
        sys_addr_i <= a;
        sys_rd_i <= rd;
        pattern <= a[15:0] ^ 16'hc35a;
        sys_req_i <= 1'b1;
        @(posedge clk_i);
        sys_req_i <= 1'b0;
        @(negedge clk_i);
    endtask

    task pulse(input logic unc);
        @(posedge clk_i);
        corr_cmd <= !unc;
        unc_cmd <= unc;
        @(posedge clk_i);
        corr_cmd <= 1'b0;
        unc_cmd <= 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task test_reset;
        chk({sel_o, bank_en_o, led_corr_o, led_unc_o, irq_o, avs_waitrequest_o}, 32'h1);
        avm(1'b1, 4'hc, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            avm(1'b0, 4'(i * 4), 32'h0);
            chk(rdv, 32'h0);
        end
        $display("reset test done");
    endtask

    task test_window;
        int banks, start, a;
        logic hit;
        rd_exp = 32'h0;
        start = 32'h23 << 12;
        for (int k = 0; k < 4; k++) begin
            banks = (k == 0) ? 4 : k;
            avm(1'b1, ecab_pkg::OFS_CTRL, {22'h0, k[0], k[1], 8'h23});
            avm(1'b0, ecab_pkg::OFS_CTRL, 32'h0);
            chk(rdv, {22'h0, k[0], k[1], 8'h23});
            for (int i = 0; i < 5; i++) begin
                a = (i == 0) ? start - 1 : start + ((i == 2) ? (banks - 1) * 32768 : (i / 3) * banks * 32768 - (i / 3) + (i / 4));
                hit = (i > 0) && (i < 4);
                sys(a[19:0], 1'b1);
                if (hit) rd_exp = {~(a[15:0] ^ 16'hc35a), a[15:0] ^ 16'hc35a};
                chk(sel_o, hit);
                chk(bank_en_o, hit ? 32'h1 << ((a - start) >> 15) : 32'h0);
                chk({row_even_en_o, row_odd_en_o}, hit ? 2'b11 : 2'b00);
                chk(rd_data_o, rd_exp);
            end
        end
        sys(20'h23001, 1'b0);
        chk({row_even_en_o, row_odd_en_o}, 2'b01);
        sys(20'h23002, 1'b0);
        chk({row_even_en_o, row_odd_en_o}, 2'b10);
        $display("window test done");
    endtask

    task test_errors;
        pulse(1'b0);
        chk({led_unc_o, led_corr_o, irq_o}, 3'b010);
        avm(1'b1, ecab_pkg::OFS_MASK, 32'h1);
        repeat (2) @(negedge clk_i);
        chk(irq_o, 1'b1);
        avm(1'b1, ecab_pkg::OFS_STATUS, 32'h1);
        repeat (2) @(negedge clk_i);
        chk({led_corr_o, irq_o}, 2'b10);
        pulse(1'b1);
        chk({led_unc_o, irq_o}, 2'b10);
        avm(1'b0, ecab_pkg::OFS_STATUS, 32'h0);
        chk(rdv, 32'h2);
        pulse(1'b0);
        chk({led_unc_o, led_corr_o}, 2'b11);
        avm(1'b1, ecab_pkg::OFS_CTRL, 32'h10023);
        repeat (2) @(negedge clk_i);
        chk({led_unc_o, led_corr_o}, 2'b00);
        // clock enable low: an error pulse must not be taken
        @(posedge clk_i);
        ce <= 1'b0;
        pulse(1'b0);
        @(posedge clk_i);
        ce <= 1'b1;
        @(negedge clk_i);
        chk({led_unc_o, led_corr_o}, 2'b00);
        $display("error test done");
    endtask

    // mid-run reset stands for a power cycle
    task test_power;
        pulse(1'b1);
        chk(led_unc_o, 1'b1);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        chk({led_unc_o, led_corr_o, irq_o, sel_o}, 4'h0);
        avm(1'b0, ecab_pkg::OFS_CTRL, 32'h0);
        chk(rdv, 32'h0);
        $display("power test done");
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    // main sequence
    initial begin
        {clk_i, reset_n_i, avs_read_i, avs_write_i, sys_req_i, sys_rd_i, corr_cmd, unc_cmd} = 8'h00;
        {avs_address_i, avs_writedata_i, sys_addr_i} = 56'h0;
        {err_total, checked, cycles} = {32'h0, 32'h0, 32'h0};
        pattern = 16'h0000;
        ce = 1'b1;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        test_reset();
        test_window();
        test_errors();
        test_power();
        conclude();
    end
endmodule

// ### testbench/ecab_ctl_model.sv
// partner model of the controller board: stored words and error pulses
// assumes bench commands are one-cycle pulses on clk_i
`timescale 1ns/1ps
module ecab_ctl_model (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    // bench commands
    input  wire logic [15:0]                 pattern_i,
    input  wire logic                        corr_cmd_i,
    input  wire logic                        unc_cmd_i,
    // array side
    output logic [ecab_pkg::WORD_W-1:0]      arr_word_even_o,
    output logic [ecab_pkg::WORD_W-1:0]      arr_word_odd_o,
    output logic                             ctl_corr_err_o,
    output logic                             ctl_unc_err_o
);
    // words with nonzero check bits that must never reach the bus
    assign arr_word_even_o = {6'h2a, pattern_i};
    assign arr_word_odd_o  = {6'h15, ~pattern_i};
    // separate one-cycle error reports
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_corr_err_o <= 1'b0;
            ctl_unc_err_o  <= 1'b0;
        end else begin
            ctl_corr_err_o <= corr_cmd_i;
            ctl_unc_err_o  <= unc_cmd_i;
        end
    end
endmodule
